// ### hdl/pca_pwm_pkg.sv
// Notes on behaviour
// R1 - bank select 0 maps compare pair to compare registers, 1 to reload
// R2 - reload words load only in 9, 10 and 11 bit shared cycle lengths
// R3 - overflow flag raises counter-array interrupt only when its enable is 1
// R4 - flag sets on overflow out of the counter bit picked by cycle length
// R5 - software writing 1 sets the flag; only software clears it
// R6 - cycle length select 00/01/10/11 gives 8/9/10/11 bit cycles
// R7 - shared cycle length applies to pwm channels not in wide mode only
// R8 - config bits 4 to 2 read zero and ignore writes
// R9 - each module has its own wide pwm select bit choosing 16 bit cycles
// R10 - gated overflow request ored with other counter-array irq sources
package pca_pwm_pkg;
    localparam int NUM_MODULES = 3;
    localparam logic [7:0] CFG_ADDR = 8'hf7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BANK_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int FLAG_BIT = 5;
    localparam int LEN_LSB = 0;
    localparam logic [NUM_MODULES-1:0][7:0] CC_LO_ADDR = {8'ha4, 8'ha2, 8'ha0};
    localparam logic [NUM_MODULES-1:0][7:0] CC_HI_ADDR = {8'ha5, 8'ha3, 8'ha1};
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [1:0] LEN_8 = 2'h0;
    localparam logic [1:0] LEN_9 = 2'h1;
    localparam logic [1:0] LEN_10 = 2'h2;
    localparam logic [1:0] LEN_11 = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic bank;
        logic irq_en;
        logic flag;
        logic [1:0] len;
    } cfg_t;
endpackage

// ### hdl/reload_word.sv
`timescale 1ns/1ps
`default_nettype none
module reload_word
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [15:0] value
);
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            value <= pca_pwm_pkg::RELOAD_RESET;
        end
        else if (ce)
        begin
            if (wr_lo)
            begin
                value[7:0] <= wdata;
            end
            if (wr_hi)
            begin
                value[15:8] <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/pca_pwm_cycle_config.sv
`timescale 1ns/1ps
`default_nettype none
module pca_pwm_cycle_config
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire pca_pwm_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rsel,
    input wire logic [7:0] cc_rdata,
    output logic cc_wr,
    output logic [7:0] cc_wr_addr,
    output logic [7:0] cc_wr_data,
    input wire logic [15:0] counter_value,
    input wire logic counter_tick,
    input wire logic [2:0] pwm_enable,
    input wire logic [2:0] wide_pwm_select,
    input wire logic other_irq_req,
    output logic [2:0][15:0] reload_value,
    output logic [2:0] reload_load,
    output logic [2:0] shared_len_en,
    output logic [1:0] cycle_length_select,
    output logic reload_bank_select,
    output logic cycle_overflow_irq_enable,
    output logic cycle_overflow_flag,
    output logic pca_irq
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic cfg_hit;
    wire logic cfg_wr;
    wire logic [2:0] lo_hit;
    wire logic [2:0] hi_hit;
    wire logic cc_hit;
    wire logic [2:0][7:0] rl_byte;
    wire logic [7:0] rl_rd;
    wire logic [2:0] rl_wr_lo;
    wire logic [2:0] rl_wr_hi;

    assign cfg_hit = sfr_req.addr == pca_pwm_pkg::CFG_ADDR;
    assign cfg_wr = cfg_hit && sfr_req.wr;

    genvar n;
    generate
        for (n = 0; n < pca_pwm_pkg::NUM_MODULES; n++)
        begin : g_mod
            assign lo_hit[n] = sfr_req.addr == pca_pwm_pkg::CC_LO_ADDR[n];
            assign hi_hit[n] = sfr_req.addr == pca_pwm_pkg::CC_HI_ADDR[n];
            assign rl_byte[n] = lo_hit[n] ? reload_value[n][7:0] :
                                hi_hit[n] ? reload_value[n][15:8] : 8'h00;
            // reload words written only with bank select at 1
            assign rl_wr_lo[n] = sfr_req.wr && lo_hit[n] &&
                                 reload_bank_select; // R1
            assign rl_wr_hi[n] = sfr_req.wr && hi_hit[n] &&
                                 reload_bank_select; // R1
            reload_word u_reload
            (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .wr_lo(rl_wr_lo[n]),
                .wr_hi(rl_wr_hi[n]),
                .wdata(sfr_req.wdata),
                .value(reload_value[n])
            );
        end
    endgenerate

    assign cc_hit = |{lo_hit, hi_hit};
    assign rl_rd = rl_byte[0] | rl_byte[1] | rl_byte[2];

    // ------------------------------------------------------------
    // overflow detect
    // ------------------------------------------------------------
    wire logic [10:0] len_mask;
    wire logic ovf_event;
    wire logic [2:0] shared_next;
    wire logic wide_len;

    assign len_mask = (cycle_length_select == pca_pwm_pkg::LEN_8) ? 11'h0ff :
                      (cycle_length_select == pca_pwm_pkg::LEN_9) ? 11'h1ff :
                      (cycle_length_select == pca_pwm_pkg::LEN_10) ? 11'h3ff :
                      11'h7ff; // R6
    assign ovf_event = counter_tick &&
                       (&(counter_value[10:0] | ~len_mask)); // R4
    assign shared_next = pwm_enable & ~wide_pwm_select; // R7 R9
    assign wide_len = cycle_length_select != pca_pwm_pkg::LEN_8;

    // ------------------------------------------------------------
    // config byte next values
    // ------------------------------------------------------------
    wire logic flag_next;
    wire logic [7:0] cfg_rd;
    wire logic [7:0] rd_next;
    wire logic [2:0] load_next;
    wire logic irq_next;
    wire logic rd_hit;
    wire logic cc_fwd;
    wire logic cc_cap;

    assign rd_hit = sfr_req.rd && (cfg_hit || cc_hit);
    assign cc_fwd = sfr_req.wr && cc_hit && !reload_bank_select; // R1
    assign cc_cap = sfr_req.wr && cc_hit;

    // set wins over a clear in the same cycle
    assign flag_next = ovf_event ||
                       (cfg_wr ? sfr_req.wdata[pca_pwm_pkg::FLAG_BIT] :
                                 cycle_overflow_flag); // R4 R5
    assign cfg_rd = {reload_bank_select, cycle_overflow_irq_enable,
                     cycle_overflow_flag, 3'h0, cycle_length_select}; // R8
    assign rd_next = cfg_hit ? cfg_rd :
                     (cc_hit && reload_bank_select) ? rl_rd :
                     cc_hit ? cc_rdata : 8'h00; // R1
    assign load_next = (ovf_event && wide_len) ? shared_next : 3'h0; // R2
    assign irq_next = (flag_next && cycle_overflow_irq_enable) ||
                      other_irq_req; // R3 R10

    // ------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cycle_overflow_flag <=
                pca_pwm_pkg::CFG_RESET[pca_pwm_pkg::FLAG_BIT];
        end
        else if (ce)
        begin
            cycle_overflow_flag <= flag_next; // R5
        end
    end

    // ------------------------------------------------------------
    // config register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reload_bank_select <=
                pca_pwm_pkg::CFG_RESET[pca_pwm_pkg::BANK_BIT];
            cycle_overflow_irq_enable <=
                pca_pwm_pkg::CFG_RESET[pca_pwm_pkg::IRQ_EN_BIT];
            cycle_length_select <=
                pca_pwm_pkg::CFG_RESET[pca_pwm_pkg::LEN_LSB +: 2];
        end
        else if (ce)
        begin
            if (cfg_wr)
            begin
                reload_bank_select <= sfr_req.wdata[pca_pwm_pkg::BANK_BIT];
                cycle_overflow_irq_enable <=
                    sfr_req.wdata[pca_pwm_pkg::IRQ_EN_BIT];
                cycle_length_select <=
                    sfr_req.wdata[pca_pwm_pkg::LEN_LSB +: 2]; // R6
            end
        end
    end

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= 8'h00;
            sfr_rsel <= 1'b0;
        end
        else if (ce)
        begin
            sfr_rsel <= rd_hit;
            if (sfr_req.rd)
            begin
                sfr_rdata <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // compare forwarding
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cc_wr <= 1'b0;
            cc_wr_addr <= 8'h00;
            cc_wr_data <= 8'h00;
        end
        else if (ce)
        begin
            cc_wr <= cc_fwd; // R1
            if (cc_cap)
            begin
                cc_wr_addr <= sfr_req.addr;
                cc_wr_data <= sfr_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // channel control and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reload_load <= 3'h0;
            shared_len_en <= 3'h0;
            pca_irq <= 1'b0;
        end
        else if (ce)
        begin
            reload_load <= load_next; // R2
            shared_len_en <= shared_next; // R7
            pca_irq <= irq_next; // R3
        end
    end
endmodule
`default_nettype wire

// ### dv/pwm_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// config checks
// ----
module pwm_cfg_checker
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire pca_pwm_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rsel,
    input wire logic cc_wr,
    input wire logic [7:0] cc_wr_data,
    input wire logic [15:0] counter_value,
    input wire logic counter_tick,
    input wire logic [2:0] pwm_enable,
    input wire logic [2:0] wide_pwm_select,
    input wire logic other_irq_req,
    input wire logic [2:0] reload_load,
    input wire logic [2:0] shared_len_en,
    input wire logic [1:0] cycle_length_select,
    input wire logic reload_bank_select,
    input wire logic cycle_overflow_irq_enable,
    input wire logic cycle_overflow_flag,
    input wire logic pca_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire [10:0] m = 11'h7ff >> (2'h3 - cycle_length_select);
    wire ovf = ce & counter_tick & ((counter_value[10:0] & m) == m);
    wire cfg_wr = ce & sfr_req.wr & (sfr_req.addr == 8'hf7);
    wire [7:0] cfg = {reload_bank_select, cycle_overflow_irq_enable,
        cycle_overflow_flag, 3'h0, cycle_length_select};
    wire [2:0] sh = pwm_enable & ~wide_pwm_select;
    sequence s_cfg_rd;
        ce && sfr_req.rd && sfr_req.addr == 8'hf7;
    endsequence
    property p_ovf; ovf |=> cycle_overflow_flag; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");
    property p_hold; cycle_overflow_flag && !cfg_wr |=> cycle_overflow_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_sw; cfg_wr && sfr_req.wdata[5] |=> cycle_overflow_flag;
    endproperty
    a_sw: assert property (p_sw) else $error("flag not set");
    property p_on; cycle_overflow_flag && cycle_overflow_irq_enable &&
        $past(cycle_overflow_irq_enable) |-> pca_irq; endproperty
    a_on: assert property (p_on) else $error("irq missing");
    property p_off; !cycle_overflow_irq_enable && !$past(other_irq_req) &&
        !$past(cycle_overflow_irq_enable) |-> !pca_irq; endproperty
    a_off: assert property (p_off) else $error("irq unmasked");
    property p_rd; s_cfg_rd |=> sfr_rsel && sfr_rdata == $past(cfg);
    endproperty
    a_rd: assert property (p_rd) else $error("bad readback");
    property p_cc; cc_wr |-> $past(ce && sfr_req.wr && !reload_bank_select)
        && cc_wr_data == $past(sfr_req.wdata); endproperty
    a_cc: assert property (p_cc) else $error("bad compare write");
    property p_rl; reload_load == ({3{$past(ovf &&
        cycle_length_select != 2'h0)}} & $past(sh)); endproperty
    a_rl: assert property (p_rl) else $error("bad reload");
    property p_sh; shared_len_en == $past(sh); endproperty
    a_sh: assert property (p_sh) else $error("bad shared");
endmodule
bind pca_pwm_cycle_config pwm_cfg_checker i_chk (.clk_sys, .rst, .ce,
    .sfr_req, .sfr_rdata, .sfr_rsel, .cc_wr, .cc_wr_data, .counter_value,
    .counter_tick, .pwm_enable, .wide_pwm_select, .other_irq_req,
    .reload_load, .shared_len_en, .cycle_length_select, .reload_bank_select,
    .cycle_overflow_irq_enable, .cycle_overflow_flag, .pca_irq);
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// config bench
// ----
module testbench;
    logic clk_sys, rst, ce, counter_tick, other_irq_req, cc_wr, sfr_rsel;
    logic reload_bank_select, cycle_overflow_irq_enable, pca_irq;
    logic cycle_overflow_flag;
    pca_pwm_pkg::sfr_req_t sfr_req;
    logic [7:0] sfr_rdata, cc_wr_addr, cc_wr_data, rd_v;
    logic [15:0] counter_value;
    logic [2:0] pwm_enable, wide_pwm_select, reload_load, shared_len_en;
    logic [2:0][15:0] reload_value;
    logic [1:0] cycle_length_select;
    int fail_count = 0;
    int n_tests = 0;
    pca_pwm_cycle_config i_dut (.clk_sys, .rst, .ce, .sfr_req, .sfr_rdata,
        .sfr_rsel, .cc_rdata(8'h5a), .cc_wr, .cc_wr_addr, .cc_wr_data,
        .counter_value, .counter_tick, .pwm_enable, .wide_pwm_select,
        .other_irq_req, .reload_value, .reload_load, .shared_len_en,
        .cycle_length_select, .reload_bank_select, .cycle_overflow_flag,
        .cycle_overflow_irq_enable, .pca_irq);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{a, 1'b1, 1'b0, d};
        @(negedge clk_sys);
        sfr_req = '0;
    endtask
    task rd(input logic [7:0] a);
        sfr_req = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clk_sys);
        sfr_req = '0;
        rd_v = sfr_rdata;
    endtask
    task tick(input logic [15:0] v);
        counter_value = v;
        counter_tick = 1'b1;
        @(negedge clk_sys);
        counter_tick = 1'b0;
    endtask
    task close_out;
        $display("tests %0d fails %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        {rst, ce, counter_tick, other_irq_req} = 4'hc;
        {sfr_req, counter_value, pwm_enable} = '0;
        wide_pwm_select = 3'h4;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'hf7);
        chk(rd_v, 16'h0);
        chk(sfr_rsel, 16'h1);
        pwm_enable = 3'h7;
        wr(8'hf7, 8'hff);
        rd(8'hf7);
        chk(rd_v, 16'he3);
        chk(pca_irq, 16'h1);
        wr(8'hf7, 8'h23);
        @(negedge clk_sys);
        chk(pca_irq, 16'h0);
        other_irq_req = 1'b1;
        @(negedge clk_sys);
        chk(pca_irq, 16'h1);
        other_irq_req = 1'b0;
        chk(shared_len_en, 16'h3);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'hf7, 8'(s));
            tick(16'((1 << (8 + s)) - 2));
            chk(cycle_overflow_flag, 16'h0);
            tick(16'((1 << (8 + s)) - 1));
            chk(cycle_overflow_flag, 16'h1);
            chk(reload_load, (s != 0) ? 16'h3 : 16'h0);
        end
        wr(8'hf7, 8'h80);
        wr(8'ha0, 8'h12);
        chk(cc_wr, 16'h0);
        wr(8'ha1, 8'h34);
        chk(reload_value[0], 16'h3412);
        rd(8'ha0);
        chk(rd_v, 16'h12);
        wr(8'hf7, 8'h00);
        rd(8'ha0);
        chk(rd_v, 16'h5a);
        ce = 1'b0;
        wr(8'hf7, 8'he1);
        tick(16'h00ff);
        ce = 1'b1;
        rd(8'hf7);
        chk(rd_v, 16'h00);
        wr(8'ha2, 8'h56);
        chk(cc_wr, 16'h1);
        chk({cc_wr_addr, cc_wr_data}, 16'ha256);
        close_out;
    end
endmodule
`default_nettype wire
